// [sbml_cfg.svh]
`ifndef SBML_CFG_SVH
`define SBML_CFG_SVH
`define SBML_OFF_CTRL 8'h00
`define SBML_OFF_STATUS 8'h04
`define SBML_OFF_TDIV 8'h08
`define SBML_OFF_ERROPT 8'h0c
`define SBML_OFF_SAMASK 8'h10
`define SBML_OFF_MCMASK 8'h14
`define SBML_OFF_BUFSTART 8'h18
`define SBML_OFF_BUFSIZE 8'h1c
`define SBML_OFF_WRPOS 8'h20
`define SBML_OFF_TIME 8'h24
`define SBML_CTRL_EN 0
`define SBML_CTRL_OVFIE 1
`define SBML_ST_OVF 0
`define SBML_ST_DMAERR 1
`define SBML_ST_BUSY 2
`define SBML_ERR_MC 1
`define SBML_ERR_UNEXP 2
`define SBML_ERR_MANPAR 3
`define SBML_WS_OK 2'h0
`define SBML_WS_MANCH 2'h1
`define SBML_WS_PARITY 2'h2
`define SBML_TIME_MARK 8'h80
`define SBML_ENTRY_BYTES 32'h00000008
`define SBML_HALF_BYTES 32'h00000004
`define SBML_TICK_NS 1000
`define SBML_CLK_NS 10
`define SBML_TICK_CYC (`SBML_TICK_NS / `SBML_CLK_NS)
`endif

// [sbml_pkg.sv]
package sbml_pkg;
  typedef struct packed {
    logic bus_b;
    logic [1:0] status;
    logic is_sync;
    logic is_command;
    logic bad_mode_code;
    logic unexp_data;
    logic [15:0] data;
  } sbml_word_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sbml_mem_t;

  typedef enum logic [1:0] {
    SBML_IDLE = 2'b00,
    SBML_WR_TIME = 2'b01,
    SBML_WR_DATA = 2'b10
  } sbml_state_t;
endpackage : sbml_pkg

// [sbml_top.sv]
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/100ps
`include "sbml_cfg.svh"

// Summary of operation
// - Time advances every divider plus one ticks.
// - Error option bits 1..3 select error logging.
// - One subaddress mask bit per subaddress.
// - Mode code mask filters mode commands.
// - Time half: bit31 one, time tag.
// - Data half: zero top, bit19 bus.
// - Bits 18:17 carry word status.
// - Bit16 word type, low 16 data.
// - Enable starts logging and interrupts.
// - Disabled monitor ignores bus, only memory error interrupts.
// - Time counter readable by host.
// - Counter wrap sets sticky overflow flag.
// - Overflow interrupt when enabled.
// - Each word writes time then data.
// - Log memory error raises interrupt.
// - Base tick is one microsecond.
module sbml_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Decoded bus words
  input wire logic word_valid,
  input wire sbml_pkg::sbml_word_t word_in,
  // Log memory write port
  output sbml_pkg::sbml_mem_t mem_out,
  input wire logic mem_ack,
  input wire logic mem_err,
  // Interrupt
  output logic irq
);
  import sbml_pkg::*;

  logic enable;
  logic next_enable;
  logic ovf_ie;
  logic next_ovf_ie;
  logic [7:0] time_div;
  logic [7:0] next_time_div;
  logic [3:1] err_opt;
  logic [3:1] next_err_opt;
  logic [31:0] sa_mask;
  logic [31:0] next_sa_mask;
  logic [31:0] mc_mask;
  logic [31:0] next_mc_mask;
  logic [31:0] buf_start;
  logic [31:0] next_buf_start;
  logic [31:0] buf_size;
  logic [31:0] next_buf_size;
  logic [6:0] pre_cnt;
  logic [6:0] next_pre_cnt;
  logic [7:0] div_cnt;
  logic [7:0] next_div_cnt;
  logic [23:0] time_tag;
  logic [23:0] next_time_tag;
  logic ovf_flag;
  logic next_ovf_flag;
  logic dma_flag;
  logic next_dma_flag;
  logic [31:0] next_reg_rdata;
  logic next_irq;

  sbml_state_t state;
  sbml_state_t next_state;
  logic xfer_keep;
  logic next_xfer_keep;
  logic [31:0] entry_data;
  logic [31:0] next_entry_data;
  logic [31:0] wr_pos;
  logic [31:0] next_wr_pos;
  sbml_mem_t next_mem_out;

  logic dma_fail;
  logic take;
  logic cmd_keep;
  logic [4:0] sub_addr;
  logic [4:0] mode_code;
  logic is_mode;
  logic [31:0] pos_step;
  logic [31:0] size_al;

  assign dma_fail = mem_out.req & mem_err;
  assign sub_addr = word_in.data[9:5];
  assign mode_code = word_in.data[4:0];
  // Subaddresses 0 and 31 carry mode commands.
  assign is_mode = (sub_addr == 5'h00) | (sub_addr == 5'h1f);
  assign cmd_keep = sa_mask[sub_addr] & (~is_mode | mc_mask[mode_code]);
  // Low size bits are dropped so the buffer holds only whole 8-byte entries.
  assign size_al = {buf_size[31:3], 3'h0};
  assign pos_step = wr_pos + `SBML_ENTRY_BYTES;

  // Configuration, time base and status.
  always_comb
  begin
    next_enable = enable;
    next_ovf_ie = ovf_ie;
    next_time_div = time_div;
    next_err_opt = err_opt;
    next_sa_mask = sa_mask;
    next_mc_mask = mc_mask;
    next_buf_start = buf_start;
    next_buf_size = buf_size;
    next_pre_cnt = pre_cnt;
    next_div_cnt = div_cnt;
    next_time_tag = time_tag;
    next_ovf_flag = ovf_flag;
    next_dma_flag = dma_flag;
    next_reg_rdata = 32'h00000000;
    if (reg_wr)
    begin
      case (reg_addr)
        `SBML_OFF_CTRL:
        begin
          next_enable = reg_wdata[`SBML_CTRL_EN];
          next_ovf_ie = reg_wdata[`SBML_CTRL_OVFIE];
        end
        `SBML_OFF_STATUS:
        begin
          if (reg_wdata[`SBML_ST_OVF])
            next_ovf_flag = 1'b0;
          if (reg_wdata[`SBML_ST_DMAERR])
            next_dma_flag = 1'b0;
        end
        `SBML_OFF_TDIV: next_time_div = reg_wdata[7:0];
        `SBML_OFF_ERROPT: next_err_opt = reg_wdata[3:1];
        `SBML_OFF_SAMASK: next_sa_mask = reg_wdata;
        `SBML_OFF_MCMASK: next_mc_mask = reg_wdata;
        `SBML_OFF_BUFSTART: next_buf_start = reg_wdata;
        `SBML_OFF_BUFSIZE: next_buf_size = reg_wdata;
        default: ;
      endcase
    end
    // One base tick per microsecond, then the divider stretches it.
    if (pre_cnt == 7'(`SBML_TICK_CYC - 1))
    begin
      next_pre_cnt = 7'h00;
      // Greater-or-equal keeps a lowered divider from stalling the count for a full lap.
      if (div_cnt >= time_div)
      begin
        next_div_cnt = 8'h00;
        next_time_tag = time_tag + 24'h000001;
        // A second wrap before the clear is merged into the same flag.
        if (&time_tag)
          next_ovf_flag = 1'b1;
      end
      else
        next_div_cnt = div_cnt + 8'h01;
    end
    else
      next_pre_cnt = pre_cnt + 7'h01;
    // The error wins over a host write that re-enables in the same cycle.
    if (dma_fail)
    begin
      next_dma_flag = 1'b1;
      next_enable = 1'b0;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `SBML_OFF_CTRL: next_reg_rdata = {30'h0, ovf_ie, enable};
        `SBML_OFF_STATUS: next_reg_rdata = {29'h0, state != SBML_IDLE, dma_flag, ovf_flag};
        `SBML_OFF_TDIV: next_reg_rdata = {24'h0, time_div};
        `SBML_OFF_ERROPT: next_reg_rdata = {28'h0, err_opt, 1'b0};
        `SBML_OFF_SAMASK: next_reg_rdata = sa_mask;
        `SBML_OFF_MCMASK: next_reg_rdata = mc_mask;
        `SBML_OFF_BUFSTART: next_reg_rdata = buf_start;
        `SBML_OFF_BUFSIZE: next_reg_rdata = buf_size;
        `SBML_OFF_WRPOS: next_reg_rdata = wr_pos;
        `SBML_OFF_TIME: next_reg_rdata = {8'h00, time_tag};
        default: next_reg_rdata = 32'h00000000;
      endcase
    end
    // The overflow source is gated by the enable, the memory error is not,
    // so a stop caused by the error is still reported.
    next_irq = (enable & ovf_ie & ovf_flag) | dma_flag;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable <= 1'b0;
      ovf_ie <= 1'b0;
      time_div <= 8'h00;
      err_opt <= 3'h0;
      sa_mask <= 32'h00000000;
      mc_mask <= 32'h00000000;
      buf_start <= 32'h00000000;
      buf_size <= 32'h00000000;
      pre_cnt <= 7'h00;
      div_cnt <= 8'h00;
      time_tag <= 24'h000000;
      ovf_flag <= 1'b0;
      dma_flag <= 1'b0;
      reg_rdata <= 32'h00000000;
      irq <= 1'b0;
    end
    else
    begin
      enable <= next_enable;
      ovf_ie <= next_ovf_ie;
      time_div <= next_time_div;
      err_opt <= next_err_opt;
      sa_mask <= next_sa_mask;
      mc_mask <= next_mc_mask;
      buf_start <= next_buf_start;
      buf_size <= next_buf_size;
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      time_tag <= next_time_tag;
      ovf_flag <= next_ovf_flag;
      dma_flag <= next_dma_flag;
      reg_rdata <= next_reg_rdata;
      irq <= next_irq;
    end
  end

  // Word filter and log writer.
  always_comb
  begin
    next_state = state;
    next_xfer_keep = xfer_keep;
    next_entry_data = entry_data;
    next_wr_pos = wr_pos;
    next_mem_out = mem_out;
    take = 1'b0;
    if (word_valid && enable)
    begin
      if (word_in.is_command)
        next_xfer_keep = cmd_keep;
      if (word_in.status != `SBML_WS_OK)
        take = err_opt[`SBML_ERR_MANPAR];
      else if (word_in.bad_mode_code)
        take = err_opt[`SBML_ERR_MC];
      else if (word_in.unexp_data)
        take = err_opt[`SBML_ERR_UNEXP];
      else if (word_in.is_command)
        take = cmd_keep;
      else
        take = xfer_keep;
    end
    if (reg_wr && (reg_addr == `SBML_OFF_BUFSTART || reg_addr == `SBML_OFF_BUFSIZE))
      next_wr_pos = 32'h00000000;
    unique case (state)
      SBML_IDLE:
      begin
        // A word that arrives while an entry is being written is lost.
        if (take)
        begin
          next_entry_data = {12'h000, word_in.bus_b, word_in.status,
                             word_in.is_sync, word_in.data};
          next_mem_out.req = 1'b1;
          next_mem_out.addr = {buf_start[31:3], 3'h0} + wr_pos;
          next_mem_out.wdata = {`SBML_TIME_MARK, time_tag};
          next_state = SBML_WR_TIME;
        end
      end
      SBML_WR_TIME:
      begin
        if (mem_err)
        begin
          next_mem_out.req = 1'b0;
          next_state = SBML_IDLE;
        end
        else if (mem_ack)
        begin
          next_mem_out.addr = mem_out.addr + `SBML_HALF_BYTES;
          next_mem_out.wdata = entry_data;
          next_state = SBML_WR_DATA;
        end
      end
      SBML_WR_DATA:
      begin
        if (mem_err)
        begin
          next_mem_out.req = 1'b0;
          next_state = SBML_IDLE;
        end
        else if (mem_ack)
        begin
          next_mem_out.req = 1'b0;
          if (pos_step >= size_al)
            next_wr_pos = 32'h00000000;
          else
            next_wr_pos = pos_step;
          next_state = SBML_IDLE;
        end
      end
      default:
      begin
        next_mem_out.req = 1'b0;
        next_state = SBML_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= SBML_IDLE;
      xfer_keep <= 1'b0;
      entry_data <= 32'h00000000;
      wr_pos <= 32'h00000000;
      mem_out <= '0;
    end
    else
    begin
      state <= next_state;
      xfer_keep <= next_xfer_keep;
      entry_data <= next_entry_data;
      wr_pos <= next_wr_pos;
      mem_out <= next_mem_out;
    end
  end
endmodule : sbml_top

// [sbml_mem.sv]
`timescale 1ns/100ps
module sbml_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Log write port
  input wire sbml_pkg::sbml_mem_t mem_out,
  input wire logic [3:0] delay,
  input wire logic fail,
  output logic mem_ack,
  output logic mem_err
);
  import sbml_pkg::*;
  int cnt;
  // The answer is one pulse; the cycle after it is skipped so the next half is seen fresh.
  always @(posedge clk)
  begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    cnt <= cnt + 1;
    if (rst || !mem_out.req || mem_ack || mem_err)
      cnt <= 0;
    else if (cnt >= delay)
    begin
      mem_ack <= !fail;
      mem_err <= fail;
      cnt <= 0;
    end
  end
endmodule : sbml_mem

// [sbml_top_props.sv]
`timescale 1ns/100ps
`include "sbml_cfg.svh"
module sbml_top_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Log port and interrupt
  input wire sbml_pkg::sbml_mem_t mem_out,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic irq
);
  import sbml_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_wait;
    mem_out.req && !mem_ack && !mem_err;
  endsequence
  sequence s_err;
    mem_out.req && mem_err;
  endsequence
  sequence s_time_done;
    mem_out.req && mem_ack && mem_out.wdata[31];
  endsequence
  property p_hold;
    s_wait |=> mem_out.req && $stable(mem_out.addr) && $stable(mem_out.wdata);
  endproperty
  a_hold: assert property (p_hold) else $error("request moved early");
  property p_err;
    s_err |=> !mem_out.req ##[0:1] irq;
  endproperty
  a_err: assert property (p_err) else $error("error not handled");
  property p_first;
    $rose(mem_out.req) |-> mem_out.wdata[31:24] == `SBML_TIME_MARK;
  endproperty
  a_first: assert property (p_first) else $error("time half missing");
  property p_step;
    s_time_done |=> mem_out.req && mem_out.wdata[31:20] == 12'h000
      && mem_out.addr == $past(mem_out.addr) + 32'h00000004;
  endproperty
  a_step: assert property (p_step) else $error("data half wrong");
  property p_last;
    mem_out.req && mem_ack && !mem_out.wdata[31] |=> !mem_out.req;
  endproperty
  a_last: assert property (p_last) else $error("extra half");
  property p_align;
    mem_out.req |-> mem_out.addr[2:0] == {!mem_out.wdata[31], 2'b00};
  endproperty
  a_align: assert property (p_align) else $error("entry misaligned");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data left");
  property p_rd_time;
    reg_rd && reg_addr == `SBML_OFF_TIME |=> reg_rdata[31:24] == 8'h00;
  endproperty
  a_rd_time: assert property (p_rd_time) else $error("time too wide");
endmodule : sbml_top_props
bind sbml_top sbml_top_props u_props (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_out(mem_out), .mem_ack(mem_ack),
  .mem_err(mem_err), .irq(irq));

// [sbml_top_tb.sv]
`timescale 1ns/100ps
`include "sbml_cfg.svh"
module sbml_top_tb;
  import sbml_pkg::*;
  localparam logic [31:0] ERR_OPT = 32'h0000000a;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, word_valid = 1'b0;
  logic fail = 1'b0, irq, mem_ack, mem_err, k;
  logic [7:0] reg_addr = 8'h00;
  logic [3:0] delay = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv, t0, sam, mcm, seed = 32'h0000046b;
  sbml_word_t word_in = '0, w;
  sbml_mem_t mem_out, q[$];
  int errors = 0, num_checks = 0, pos = 0, last = 0, n;
  sbml_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .word_valid(word_valid),
    .word_in(word_in), .mem_out(mem_out), .mem_ack(mem_ack), .mem_err(mem_err), .irq(irq));
  sbml_mem mem (.clk(clk), .rst(rst), .mem_out(mem_out), .delay(delay), .fail(fail),
    .mem_ack(mem_ack), .mem_err(mem_err));
  always #5 clk = ~clk;
  always @(posedge clk)
    if (mem_out.req && mem_ack)
      q.push_back(mem_out);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Every command refreshes the keep flag, even one with an error, and data words inherit it.
  function automatic logic kept(input sbml_word_t x);
    logic c;
    c = sam[x.data[9:5]] && (x.data[9:5] != 5'h00 && x.data[9:5] != 5'h1f
      || mcm[x.data[4:0]]);
    if (x.is_command)
      last = c;
    if (x.status != 2'h0)
      return ERR_OPT[`SBML_ERR_MANPAR];
    if (x.bad_mode_code)
      return ERR_OPT[`SBML_ERR_MC];
    if (x.unexp_data)
      return ERR_OPT[`SBML_ERR_UNEXP];
    return last[0];
  endfunction : kept
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic send(input sbml_word_t x, input logic e);
    n = q.size();
    @(posedge clk);
    word_valid <= 1'b1;
    word_in <= x;
    delay <= 4'(rnd());
    @(posedge clk);
    word_valid <= 1'b0;
    word_in <= ~x;
    for (int i = 0; i < 60 && q.size() < n + 2; i++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk(32'(q.size() - n), e ? 32'h2 : 32'h0, "entries");
    if (e && q.size() == n + 2)
    begin
      chk(q[n].addr, 32'h00000100 + pos, "time addr");
      chk(q[n].wdata & 32'hff000000, 32'h80000000, "time half");
      chk(q[n+1].addr, 32'h00000104 + pos, "data addr");
      chk(q[n+1].wdata, {12'h000, x.bus_b, x.status, x.is_sync, x.data}, "data");
      pos = (pos + 8) % 24;
    end
  endtask : send
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 48; a += 4)
    begin
      rd(8'(a), rv);
      chk(rv, 32'h0, "reset value");
    end
    for (int d = 0; d < 3; d++)
    begin
      wr(`SBML_OFF_TDIV, 32'(d * d + d / 2));
      rd(`SBML_OFF_TIME, t0);
      repeat (`SBML_TICK_CYC * 2 * (d * d + d / 2 + 1) - 2) @(posedge clk);
      rd(`SBML_OFF_TIME, rv);
      chk(rv - t0, 32'h2, "time step");
    end
    sam = rnd();
    mcm = rnd();
    wr(`SBML_OFF_CTRL, 32'h0);
    wr(`SBML_OFF_TDIV, 32'h0);
    wr(`SBML_OFF_ERROPT, ERR_OPT);
    wr(`SBML_OFF_SAMASK, sam);
    wr(`SBML_OFF_MCMASK, mcm);
    wr(`SBML_OFF_BUFSTART, 32'h00000100);
    wr(`SBML_OFF_BUFSIZE, 32'h00000018);
    wr(`SBML_OFF_CTRL, 32'h00000003);
    for (int i = 0; i < 30; i++)
    begin
      w = sbml_word_t'(23'(rnd()));
      w.status[1] &= ~w.status[0];
      w.is_command |= (i == 0);
      k = kept(w);
      send(w, k);
    end
    rd(`SBML_OFF_WRPOS, rv);
    chk(rv, 32'(pos), "position");
    w = '0;
    w.status = `SBML_WS_MANCH;
    wr(`SBML_OFF_CTRL, 32'h0);
    send(w, 1'b0);
    wr(`SBML_OFF_CTRL, 32'h1);
    fail <= 1'b1;
    send(w, 1'b0);
    chk(32'(irq), 32'h1, "error irq");
    rd(`SBML_OFF_STATUS, rv);
    chk(rv & 32'h2, 32'h2, "error flag");
    rd(`SBML_OFF_CTRL, rv);
    chk(rv & 32'h1, 32'h0, "auto stop");
    fail <= 1'b0;
    wr(`SBML_OFF_STATUS, 32'h2);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "irq clear");
    send(w, 1'b0);
    wr(`SBML_OFF_CTRL, 32'h1);
    send(w, 1'b1);
    conclude();
  end
endmodule : sbml_top_tb
